/* design/iedec_counter.sv */
// iedec_counter: up/down counter with reference-mark load and capture
// assumes count pulses are single-cycle and never up and down together
module iedec_counter #(
   parameter int WIDTH = iedec_pkg::CNT_WIDTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic up,
   input wire logic down,
   input wire logic ref_evt,
   input wire iedec_pkg::iedec_ref_e ref_mode,
   input wire logic [WIDTH-1:0] start_value,
   output logic [WIDTH-1:0] count,
   output logic [WIDTH-1:0] capture
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic [WIDTH-1:0] capture;
   } iedec_counter_s;
   iedec_counter_s r;
   iedec_counter_s next_r;

   always_comb begin
      next_r = r;
      if (up) begin
         next_r.count = r.count + WIDTH'(1);
      end else if (down) begin
         next_r.count = r.count - WIDTH'(1);
      end
      // a reference-mark load wins over a count pulse in the same cycle
      if (ref_evt && ref_mode == iedec_pkg::IEDEC_REF_LOAD) begin
         next_r.count = start_value;
      end
      if (ref_evt && ref_mode == iedec_pkg::IEDEC_REF_CAPTURE) begin
         next_r.capture = r.count;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign count = r.count;
   assign capture = r.capture;

   ref_load_a: assert property (@(posedge clk) disable iff (rst)
      ref_evt && ref_mode == iedec_pkg::IEDEC_REF_LOAD |=> count == $past(start_value))
      else $error("reference mark did not load start value");
   ref_capture_a: assert property (@(posedge clk) disable iff (rst)
      ref_evt && ref_mode == iedec_pkg::IEDEC_REF_CAPTURE |=> capture == $past(count))
      else $error("reference mark did not capture counter");
endmodule : iedec_counter

/* design/iedec_sync.sv */
// iedec_sync: two-stage synchroniser for a group of encoder inputs
// assumes inputs may change at any time relative to REF_CLK
module iedec_sync #(
   parameter int WIDTH = iedec_pkg::SYNC_WIDTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } iedec_sync_s;
   iedec_sync_s r;
   iedec_sync_s next_r;

   // first stage is read by the second stage only
   always_comb begin
      next_r.meta = din;
      next_r.stable = r.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         // load the pin levels so the edge detector does not see a false edge after reset
         r <= '{meta: din, stable: din};
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.stable;
endmodule : iedec_sync

/* design/iedec_top.sv */
// iedec_top: incremental encoder front end turning A/B into count pulses and N into reference events
// assumes encoder pins and analog fault detectors arrive as plain inputs
module iedec_top #(
   parameter int CNT_WIDTH = iedec_pkg::CNT_WIDTH
) (
   input wire logic REF_CLK,
   input wire logic SRST,
   input wire logic TRACK_A,
   input wire logic TRACK_B,
   input wire logic REF_MARK,
   input wire iedec_pkg::iedec_mode_e MODE,
   input wire iedec_pkg::iedec_eval_e EVAL,
   input wire iedec_pkg::iedec_ref_e REF_ACTION,
   input wire logic INVERT_DIR,
   input wire logic SW_DOWN,
   input wire logic DIFF_INPUTS,
   input wire logic SE_WIRE_BREAK,
   input wire logic SE_SUPPLY_FAULT,
   input wire logic DIFF_WIRE_BREAK,
   input wire logic DIFF_SHORT,
   input wire logic DIFF_SUPPLY_FAULT,
   input wire logic FRAME_VALID,
   input wire logic FRAME_ERROR,
   input wire logic DIAG_INT_EN,
   input wire logic FAULT_CLEAR,
   input wire logic [CNT_WIDTH-1:0] START_VALUE,
   output logic COUNT_UP,
   output logic COUNT_DOWN,
   output logic DIR_DOWN,
   output logic ENCODER_FAULT_FLAG,
   output logic SIGNAL_FAULT,
   output logic FRAME_FAULT,
   output logic DIAG_INT,
   output logic [CNT_WIDTH-1:0] COUNT_VALUE,
   output logic [CNT_WIDTH-1:0] CAPTURE_VALUE
);
   typedef struct packed {
      logic primed;
      logic a_q;
      logic b_q;
      logic n_q;
      logic up;
      logic down;
      logic dir_down;
      logic enc_fault;
      logic sig_fault;
      logic frame_fault;
      logic diag;
      logic ref_evt;
   } iedec_top_s;
   iedec_top_s r;
   iedec_top_s next_r;

   logic [2:0] pins_sync;
   logic a_s;
   logic b_s;
   logic n_s;
   logic a_rise;
   logic a_fall;
   logic b_rise;
   logic b_fall;
   logic up_raw;
   logic down_raw;
   logic sig_evt;
   logic frame_evt;

   iedec_sync #(
      .WIDTH(iedec_pkg::SYNC_WIDTH)
   ) u_sync (
      .clk(REF_CLK),
      .rst(SRST),
      .din({REF_MARK, TRACK_B, TRACK_A}),
      .dout(pins_sync)
   );

   assign a_s = pins_sync[0];
   assign b_s = pins_sync[1];
   assign n_s = pins_sync[2];
   assign a_rise = r.primed && a_s && !r.a_q;
   assign a_fall = r.primed && !a_s && r.a_q;
   assign b_rise = r.primed && b_s && !r.b_q;
   assign b_fall = r.primed && !b_s && r.b_q;

   // quadrature relies on the encoder keeping its tracks a quarter cycle apart
   always_comb begin
      up_raw = 1'b0;
      down_raw = 1'b0;
      case (MODE)
         iedec_pkg::IEDEC_QUAD: begin
            // both tracks moving in one sample has no valid phase; count nothing
            if (!((a_rise || a_fall) && (b_rise || b_fall))) begin
               case (EVAL)
                  iedec_pkg::IEDEC_X1: begin
                     up_raw = a_rise && !b_s;
                     down_raw = a_fall && !b_s;
                  end
                  iedec_pkg::IEDEC_X2: begin
                     up_raw = (a_rise && !b_s) || (a_fall && b_s);
                     down_raw = (a_fall && !b_s) || (a_rise && b_s);
                  end
                  iedec_pkg::IEDEC_X4: begin
                     up_raw = (a_rise && !b_s) || (a_fall && b_s)
                        || (b_rise && a_s) || (b_fall && !a_s);
                     down_raw = (a_fall && !b_s) || (a_rise && b_s)
                        || (b_fall && a_s) || (b_rise && !a_s);
                  end
                  default: begin
                     up_raw = 1'b0;
                     down_raw = 1'b0;
                  end
               endcase
            end
            if (INVERT_DIR) begin
               {up_raw, down_raw} = {down_raw, up_raw};
            end
         end
         iedec_pkg::IEDEC_PULSE_DIR: begin
            up_raw = a_rise && !b_s;
            down_raw = a_rise && b_s;
         end
         iedec_pkg::IEDEC_PULSE: begin
            up_raw = a_rise && !SW_DOWN;
            down_raw = a_rise && SW_DOWN;
         end
         iedec_pkg::IEDEC_UPDOWN: begin
            // simultaneous pulses cancel so the net count stays right
            up_raw = a_rise && !b_rise;
            down_raw = b_rise && !a_rise;
         end
         default: begin
            up_raw = 1'b0;
            down_raw = 1'b0;
         end
      endcase
   end

   assign sig_evt = DIFF_INPUTS
      ? (DIFF_WIRE_BREAK || DIFF_SHORT || DIFF_SUPPLY_FAULT)
      : (SE_WIRE_BREAK || SE_SUPPLY_FAULT);
   assign frame_evt = FRAME_VALID && FRAME_ERROR;

   always_comb begin
      next_r = r;
      next_r.primed = 1'b1;
      next_r.a_q = a_s;
      next_r.b_q = b_s;
      next_r.n_q = n_s;
      // the mark acts only once the edge detector holds a reference level
      next_r.ref_evt = r.primed && n_s && !r.n_q;
      next_r.up = up_raw;
      next_r.down = down_raw;
      if (up_raw) begin
         next_r.dir_down = 1'b0;
      end else if (down_raw) begin
         next_r.dir_down = 1'b1;
      end
      // set wins over a clear in the same cycle
      if (FAULT_CLEAR) begin
         next_r.enc_fault = 1'b0;
         next_r.sig_fault = 1'b0;
         next_r.frame_fault = 1'b0;
      end
      if (MODE == iedec_pkg::IEDEC_QUAD && (a_rise || a_fall) && (b_rise || b_fall)) begin
         next_r.enc_fault = 1'b1;
      end
      if (sig_evt) begin
         next_r.sig_fault = 1'b1;
      end
      if (frame_evt) begin
         next_r.frame_fault = 1'b1;
      end
      next_r.diag = DIAG_INT_EN && (sig_evt || frame_evt);
   end

   // first edge after reset only loads the reference levels, since primed is still low
   always_ff @(posedge REF_CLK) begin
      if (SRST) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // pulses are registered first so the counter sees clean one-cycle strobes
   iedec_counter #(
      .WIDTH(CNT_WIDTH)
   ) u_counter (
      .clk(REF_CLK),
      .rst(SRST),
      .up(r.up),
      .down(r.down),
      .ref_evt(r.ref_evt),
      .ref_mode(REF_ACTION),
      .start_value(START_VALUE),
      .count(COUNT_VALUE),
      .capture(CAPTURE_VALUE)
   );

   // every output is a flop; pulses stand one cycle, fault flags until cleared
   assign COUNT_UP = r.up;
   assign COUNT_DOWN = r.down;
   assign DIR_DOWN = r.dir_down;
   assign ENCODER_FAULT_FLAG = r.enc_fault;
   assign SIGNAL_FAULT = r.sig_fault;
   assign FRAME_FAULT = r.frame_fault;
   assign DIAG_INT = r.diag;

   x1_up_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_QUAD && EVAL == iedec_pkg::IEDEC_X1 && !INVERT_DIR
      && a_rise && !b_s && !b_fall |=> COUNT_UP)
      else $error("single evaluation missed up pulse");
   x1_down_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_QUAD && EVAL == iedec_pkg::IEDEC_X1 && !INVERT_DIR
      && a_fall && !b_s && !b_fall |=> COUNT_DOWN)
      else $error("single evaluation missed down pulse");
   x1_quiet_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_QUAD && EVAL == iedec_pkg::IEDEC_X1 && b_s
      |=> !COUNT_UP && !COUNT_DOWN)
      else $error("single evaluation counted with track B high");
   invert_dir_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_QUAD && EVAL == iedec_pkg::IEDEC_X2 && INVERT_DIR
      && a_rise && !b_s && !b_rise && !b_fall |=> COUNT_DOWN && !COUNT_UP)
      else $error("inversion did not reverse direction");
   x4_b_edge_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_QUAD && EVAL == iedec_pkg::IEDEC_X4 && !INVERT_DIR
      && b_rise && a_s && !a_rise && !a_fall |=> COUNT_UP)
      else $error("quadruple evaluation missed B edge");
   pulse_dir_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_PULSE_DIR && a_rise |=> (COUNT_DOWN == $past(b_s)))
      else $error("direction input not honoured");
   sw_dir_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_PULSE && a_rise |=> (COUNT_DOWN == $past(SW_DOWN)))
      else $error("program direction not honoured");
   updown_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_UPDOWN && b_rise && !a_rise |=> COUNT_DOWN)
      else $error("down track did not count down");
   bad_trans_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_QUAD && (a_rise || a_fall) && (b_rise || b_fall)
      |=> ENCODER_FAULT_FLAG && !COUNT_UP && !COUNT_DOWN)
      else $error("invalid transition not flagged");
   diag_gate_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      DIAG_INT |-> $past(DIAG_INT_EN) && (SIGNAL_FAULT || FRAME_FAULT))
      else $error("diagnostic interrupt without enable or fault");
   diff_fault_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      DIFF_INPUTS && DIFF_SHORT |=> SIGNAL_FAULT)
      else $error("differential short not reported");
   reset_quiet_a: assert property (@(posedge REF_CLK)
      $fell(SRST) |-> !COUNT_UP && !COUNT_DOWN && !ENCODER_FAULT_FLAG ##1 !COUNT_UP && !COUNT_DOWN)
      else $error("count pulse right after reset");
   // pulse checks leave out samples where the other track moved too; those count nothing
   x2_up_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_QUAD && EVAL == iedec_pkg::IEDEC_X2 && !INVERT_DIR
      && a_fall && b_s && !b_rise |=> COUNT_UP && !COUNT_DOWN)
      else $error("double evaluation missed falling A edge");
   x2_down_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_QUAD && EVAL == iedec_pkg::IEDEC_X2 && !INVERT_DIR
      && a_rise && b_s && !b_rise |=> COUNT_DOWN && !COUNT_UP)
      else $error("double evaluation missed down pulse");
   x4_b_down_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_QUAD && EVAL == iedec_pkg::IEDEC_X4 && !INVERT_DIR
      && b_fall && a_s && !a_rise && !a_fall |=> COUNT_DOWN)
      else $error("quadruple evaluation missed falling B edge");
   x1_b_quiet_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_QUAD && EVAL == iedec_pkg::IEDEC_X1 && (b_rise || b_fall)
      |=> !COUNT_UP && !COUNT_DOWN)
      else $error("single evaluation counted a B edge");
   pulse_b_quiet_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_PULSE_DIR && !a_rise |=> !COUNT_UP && !COUNT_DOWN)
      else $error("pulse mode counted without an A pulse");
   updown_up_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_UPDOWN && a_rise && !b_rise |=> COUNT_UP && !COUNT_DOWN)
      else $error("up track did not count up");
   updown_both_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      MODE == iedec_pkg::IEDEC_UPDOWN && a_rise && b_rise |=> !COUNT_UP && !COUNT_DOWN)
      else $error("simultaneous up and down pulses were counted");
   dir_track_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      COUNT_DOWN |-> DIR_DOWN)
      else $error("direction flag does not follow a down pulse");
   // fault flags stay set until a clear arrives; a new event beats the clear
   se_fault_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      !DIFF_INPUTS && (SE_WIRE_BREAK || SE_SUPPLY_FAULT) |=> SIGNAL_FAULT)
      else $error("single-ended fault not reported");
   frame_fault_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      FRAME_VALID && FRAME_ERROR |=> FRAME_FAULT)
      else $error("faulty frame not reported");
   enc_sticky_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      ENCODER_FAULT_FLAG && !FAULT_CLEAR |=> ENCODER_FAULT_FLAG)
      else $error("encoder fault flag dropped without a clear");
   diag_raise_a: assert property (@(posedge REF_CLK) disable iff (SRST)
      DIAG_INT_EN && (sig_evt || frame_evt) |=> DIAG_INT)
      else $error("enabled fault event raised no diagnostic interrupt");
endmodule : iedec_top

/* inc/iedec_pkg.sv */
// iedec_pkg: shared constants and enumerations of the incremental encoder front end
// assumes one 200 MHz clock and asynchronous inputs from the encoder pins
package iedec_pkg;
   // signal type selection
   typedef enum logic [1:0] {
      IEDEC_QUAD = 2'h0,
      IEDEC_PULSE_DIR = 2'h1,
      IEDEC_PULSE = 2'h2,
      IEDEC_UPDOWN = 2'h3
   } iedec_mode_e;
   // quadrature edge evaluation factor
   typedef enum logic [1:0] {
      IEDEC_X1 = 2'h0,
      IEDEC_X2 = 2'h1,
      IEDEC_X4 = 2'h2
   } iedec_eval_e;
   // reference mark action
   typedef enum logic [1:0] {
      IEDEC_REF_NONE = 2'h0,
      IEDEC_REF_LOAD = 2'h1,
      IEDEC_REF_CAPTURE = 2'h2
   } iedec_ref_e;
   localparam int SYNC_STAGES = 2;
   localparam int SYNC_WIDTH = 3;
   localparam int FLT_BITS = 3;
   localparam logic [2:0] FLT_RESET = 3'h0;
   localparam int CNT_WIDTH = 32;
   localparam int REF_CLK_HZ = 200000000;
endpackage : iedec_pkg

/* test/iedec_enc_model.sv */
// iedec_enc_model: behavioural encoder on the far side of the track pins
// assumes one-cycle step strobes in the REF_CLK domain; raw_en hands the pins to the bench
module iedec_enc_model (
   input wire logic clk,
   input wire logic step,
   input wire logic rev,
   input wire logic raw_en,
   input wire logic raw_a,
   input wire logic raw_b,
   input wire logic mark,
   output logic a,
   output logic b,
   output logic n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph = 2'h0;
   // one track moves per step, so the tracks stay a quarter cycle apart
   always @(posedge clk) begin
      if (step) begin
         ph <= rev ? ph - 2'h1 : ph + 2'h1;
      end
   end
   // gray order: a leads b when moving forward
   assign a = raw_en ? raw_a : (ph == 2'h1 || ph == 2'h2);
   assign b = raw_en ? raw_b : ph[1];
   // the reference mark is optional; it stays low unless a scenario asks for it
   assign n = mark;
endmodule : iedec_enc_model

/* test/iedec_tb_top.sv */
// iedec_tb_top: self-checking bench of the encoder front end
// assumes the counter resets to zero and every edge that the selected evaluation counts gives exactly one count pulse
module iedec_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic step = 1'b0, rev = 1'b0, raw_en = 1'b0, raw_a = 1'b0, raw_b = 1'b0, mark = 1'b0;
   logic inv = 1'b0, sw_down = 1'b0, diff = 1'b0, se_wb = 1'b0, se_sf = 1'b0, d_wb = 1'b0;
   logic d_sh = 1'b0, d_sf = 1'b0, f_val = 1'b0, f_err = 1'b0, int_en = 1'b0, f_clr = 1'b0;
   logic [31:0] start = 32'h0;
   iedec_pkg::iedec_mode_e mode = iedec_pkg::IEDEC_QUAD;
   iedec_pkg::iedec_eval_e eval = iedec_pkg::IEDEC_X1;
   iedec_pkg::iedec_ref_e ref_act = iedec_pkg::IEDEC_REF_NONE;
   logic a, b, n, up, dn, dir, eflag, sflt, fflt, dint;
   logic [31:0] cval, cap;
   logic [31:0] exp_cnt = 32'h0;
   int miscompares = 0, check_count = 0, ups = 0, dns = 0, diags = 0, u0 = 0, d0 = 0, i0 = 0;
   always #2.5 clk = ~clk;
   // pulses are one cycle wide, so each is counted at the edge where it stands
   always @(posedge clk) begin
      if (up === 1'b1) ups <= ups + 1;
      if (dn === 1'b1) dns <= dns + 1;
      if (dint === 1'b1) diags <= diags + 1;
   end
   iedec_enc_model enc (.clk(clk), .step(step), .rev(rev), .raw_en(raw_en), .raw_a(raw_a),
      .raw_b(raw_b), .mark(mark), .a(a), .b(b), .n(n));
   iedec_top dut (.REF_CLK(clk), .SRST(srst), .TRACK_A(a), .TRACK_B(b), .REF_MARK(n),
      .MODE(mode), .EVAL(eval), .REF_ACTION(ref_act), .INVERT_DIR(inv), .SW_DOWN(sw_down),
      .DIFF_INPUTS(diff), .SE_WIRE_BREAK(se_wb), .SE_SUPPLY_FAULT(se_sf),
      .DIFF_WIRE_BREAK(d_wb), .DIFF_SHORT(d_sh), .DIFF_SUPPLY_FAULT(d_sf),
      .FRAME_VALID(f_val), .FRAME_ERROR(f_err), .DIAG_INT_EN(int_en), .FAULT_CLEAR(f_clr),
      .START_VALUE(start), .COUNT_UP(up), .COUNT_DOWN(dn), .DIR_DOWN(dir),
      .ENCODER_FAULT_FLAG(eflag), .SIGNAL_FAULT(sflt), .FRAME_FAULT(fflt), .DIAG_INT(dint),
      .COUNT_VALUE(cval), .CAPTURE_VALUE(cap));
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask : cyc
   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_val
   // waits out sync and counter latency, then checks pulse counts and the counter
   task automatic settle(input int nu, input int nd);
      cyc(8);
      chk_val(32'(ups - u0), 32'(nu));
      chk_val(32'(dns - d0), 32'(nd));
      exp_cnt = exp_cnt + 32'(nu) - 32'(nd);
      chk_val(cval, exp_cnt);
      u0 = ups;
      d0 = dns;
   endtask : settle
   task automatic steps(input logic r, input int k);
      repeat (k) begin
         rev <= r;
         step <= 1'b1;
         cyc(1);
         step <= 1'b0;
         cyc(3);
      end
   endtask : steps
   task automatic pins(input logic pa, input logic pb);
      raw_a <= pa;
      raw_b <= pb;
      cyc(4);
   endtask : pins
   task automatic clear_flags;
      f_clr <= 1'b1;
      cyc(1);
      f_clr <= 1'b0;
      cyc(2);
   endtask : clear_flags
   task automatic t_reset;
      cyc(2);
      chk_val(cval, 32'h0);
      chk_bit(eflag, 1'b0);
      settle(0, 0);
   endtask : t_reset
   task automatic t_quad;
      steps(1'b0, 4);
      settle(1, 0);
      steps(1'b1, 4);
      settle(0, 1);
      eval <= iedec_pkg::IEDEC_X2;
      steps(1'b0, 4);
      settle(2, 0);
      eval <= iedec_pkg::IEDEC_X4;
      steps(1'b0, 4);
      settle(4, 0);
      steps(1'b1, 4);
      settle(0, 4);
      inv <= 1'b1;
      steps(1'b0, 4);
      settle(0, 4);
      chk_bit(dir, 1'b1);
      inv <= 1'b0;
   endtask : t_quad
   task automatic t_pulse;
      raw_en <= 1'b1;
      mode <= iedec_pkg::IEDEC_PULSE_DIR;
      pins(1'b0, 1'b1);
      pins(1'b1, 1'b1);
      pins(1'b0, 1'b1);
      settle(0, 1);
      pins(1'b0, 1'b0);
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      settle(1, 0);
      mode <= iedec_pkg::IEDEC_PULSE;
      sw_down <= 1'b1;
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      settle(0, 1);
      sw_down <= 1'b0;
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      settle(1, 0);
      mode <= iedec_pkg::IEDEC_UPDOWN;
      pins(1'b1, 1'b0);
      pins(1'b0, 1'b0);
      settle(1, 0);
      pins(1'b0, 1'b1);
      pins(1'b0, 1'b0);
      settle(0, 1);
   endtask : t_pulse
   // both tracks flipping in one sample has no phase offset to judge
   task automatic t_invalid;
      mode <= iedec_pkg::IEDEC_QUAD;
      pins(1'b1, 1'b1);
      settle(0, 0);
      chk_bit(eflag, 1'b1);
      pins(1'b0, 1'b0);
      settle(0, 0);
      clear_flags();
      chk_bit(eflag, 1'b0);
      raw_en <= 1'b0;
   endtask : t_invalid
   task automatic t_ref;
      start <= 32'h00ABCDEF;
      ref_act <= iedec_pkg::IEDEC_REF_LOAD;
      mark <= 1'b1;
      cyc(2);
      mark <= 1'b0;
      exp_cnt = 32'h00ABCDEF;
      settle(0, 0);
      chk_val(cval, exp_cnt);
      steps(1'b0, 4);
      settle(4, 0);
      ref_act <= iedec_pkg::IEDEC_REF_CAPTURE;
      mark <= 1'b1;
      cyc(2);
      mark <= 1'b0;
      settle(0, 0);
      chk_val(cap, exp_cnt);
   endtask : t_ref
   // reset with track A high: the present levels become the reference, no pulse follows
   task automatic t_rerst;
      raw_en <= 1'b1;
      raw_a <= 1'b1;
      raw_b <= 1'b0;
      srst <= 1'b1;
      cyc(3);
      srst <= 1'b0;
      exp_cnt = 32'h0;
      settle(0, 0);
      chk_val(cap, 32'h0);
      chk_bit(eflag, 1'b0);
   endtask : t_rerst
   // k selects the fault line: 0..1 single-ended, 2..4 differential, 5 bad frame
   task automatic t_fault(input int k, input logic en, input int nd);
      i0 = diags;
      int_en <= en;
      diff <= (k > 1);
      cyc(1);
      se_wb <= (k == 0);
      se_sf <= (k == 1);
      d_wb <= (k == 2);
      d_sh <= (k == 3);
      d_sf <= (k == 4);
      f_val <= (k == 5);
      f_err <= (k == 5);
      cyc(1);
      {se_wb, se_sf, d_wb, d_sh, d_sf, f_val, f_err} <= 7'h00;
      cyc(4);
      chk_bit((k == 5) ? fflt : sflt, 1'b1);
      chk_val(32'(diags - i0), 32'(nd));
      clear_flags();
      chk_bit(sflt | fflt, 1'b0);
   endtask : t_fault
   task automatic results;
      $display("comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results
   initial begin
      cyc(3);
      srst <= 1'b0;
      t_reset();
      t_quad();
      t_pulse();
      t_invalid();
      t_ref();
      t_rerst();
      t_fault(0, 1'b0, 0);
      t_fault(1, 1'b1, 1);
      for (int k = 2; k < 5; k++) begin
         t_fault(k, 1'b1, 1);
      end
      t_fault(5, 1'b0, 0);
      t_fault(5, 1'b1, 1);
      results();
   end
   // the scenarios need well under a thousand cycles
   initial begin
      cyc(5000);
      miscompares++;
      results();
   end
endmodule : iedec_tb_top
